//--- verilog/fwb_pkg.sv
// shared constants and types of the buffered program sequencer
package fwb_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W     = 24;            // word address
  localparam int DATA_W     = 16;            // data word
  localparam int PIN_W      = 29;            // sampled pin vector
  localparam int BUF_WORDS  = 32;            // write buffer depth
  localparam int SECTOR_LSB = 16;            // sector select bits 23:16
  localparam int PAGE_LSB   = 5;             // 32-word page
  // ==========================================================
  // command codes and offsets within a sector
  localparam logic [15:0] CMD_BUF_LOAD      = 16'h0025;
  localparam logic [15:0] CMD_BUF_CONFIRM   = 16'h0029;
  localparam logic [15:0] CMD_PGM_SUSPEND   = 16'h0051;
  localparam logic [15:0] CMD_PGM_RESUME    = 16'h0050;
  localparam logic [15:0] CMD_STATUS_READ   = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STATUS  = 16'h0071;
  localparam logic [15:0] CMD_ERASE_SUSPEND = 16'h00B0;
  localparam logic [15:0] OFS_CMD           = 16'h0555;
  localparam logic [15:0] OFS_COUNT         = 16'h02AA;
  localparam logic [15:0] MAX_COUNT_M1      = 16'h001F;
  // ==========================================================
  // status bit positions and reset values
  localparam int ST_READY = 7;
  localparam int ST_PFAIL = 4;
  localparam int ST_PSUSP = 2;
  localparam int ST_LOCK  = 1;
  localparam int ST_BANK  = 0;
  localparam logic       READ_MODE_SYNC = 1'b0;   // config bit value
  localparam logic [7:0] STATUS_RESET   = 8'h80;
  // ==========================================================
  // initiating context of a program operation
  typedef enum logic [1:0] {
    CTX_IDLE, CTX_ERASE_SUSPEND, CTX_SECURE_LOCK, CTX_SECURE_REGION
  } fwb_ctx_type;
endpackage : fwb_pkg

//--- verilog/fwb_word_if.sv
// word stream carrier between sequencer and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface fwb_word_if;
  logic        valid;   // word present
  logic        ready;   // sink takes word
  logic [23:0] addr;    // program address
  logic [15:0] data;    // merged data
  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface : fwb_word_if
`default_nettype wire

//--- verilog/fwb_pair_buf.sv
// two-entry buffer with registered outputs on both sides
`timescale 1ns/1ps
`default_nettype none
module fwb_pair_buf (
  input  wire logic   clk_i,    // core clock
  input  wire logic   rst_i,    // async reset, high
  fwb_word_if.snk     in_s,     // from sequencer
  fwb_word_if.src     out_s,    // to array programmer
  output logic        empty_o   // both entries free
);
  // ==========================================================
  // state
  typedef struct packed {
    logic        hvalid;  // head entry full
    logic [39:0] head;    // {addr,data} at output
    logic        svalid;  // spare entry full
    logic [39:0] spare;   // {addr,data} held on stall
  } fwb_buf_type;
  fwb_buf_type s, next_s;
  logic pop, push;
  // ==========================================================
  // next state: spare only fills while head is stalled
  always_comb begin
    next_s = s;
    pop    = s.hvalid & out_s.ready;
    push   = in_s.valid & ~s.svalid;
    if (!s.hvalid || pop) begin
      if (s.svalid) begin           // spare moves to head
        next_s.head   = s.spare;
        next_s.hvalid = 1'b1;
        next_s.svalid = 1'b0;
      end else begin
        next_s.hvalid = push;
        if (push) next_s.head = {in_s.addr, in_s.data};
      end
    end else if (push) begin        // head stalled, park word
      next_s.svalid = 1'b1;
      next_s.spare  = {in_s.addr, in_s.data};
    end
  end
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) s <= '0;
    else       s <= next_s;
  end
  assign in_s.ready  = ~s.svalid;
  assign out_s.valid = s.hvalid;
  assign out_s.addr  = s.head[39:16];
  assign out_s.data  = s.head[15:0];
  assign empty_o     = ~s.hvalid & ~s.svalid;
endmodule : fwb_pair_buf
`default_nettype wire

//--- verilog/fwb_seq.sv
// command write front end and write buffer program sequencer
`timescale 1ns/1ps
`default_nettype none
module fwb_seq (
  input  wire logic               clk_i,                  // core clock
  input  wire logic               rst_i,                  // async reset, high
  input  wire logic               ce_n_i,                 // chip select pin
  input  wire logic               we_n_i,                 // write strobe pin
  input  wire logic               oe_n_i,                 // output enable pin
  input  wire logic               address_valid_n_i,      // address strobe pin
  input  wire logic               link_clk_i,             // bus clock pin
  input  wire logic [15:0]        adq_i,                  // muxed addr/data
  input  wire logic [7:0]         addr_hi_i,              // upper address
  input  wire logic               read_mode_select_bit_i, // 0 sync reads
  input  wire fwb_pkg::fwb_ctx_type context_i,            // current context
  input  wire logic               erase_busy_i,           // erase running
  input  wire logic [7:0]         erase_sector_i,         // erasing sector
  input  wire logic               sector_unlocked_i,      // target unlocked
  input  wire logic [7:0]         rd_sector_i,            // sector read now
  input  wire logic [15:0]        arr_rd_data_i,          // array word
  input  wire logic               prog_ready_i,           // programmer ready
  output logic [23:0]             arr_rd_addr_o,          // array read addr
  output logic [7:0]              sector_select_bits_o,   // target sector
  output logic                    prog_valid_o,           // word to program
  output logic [23:0]             prog_addr_o,            // program address
  output logic [15:0]             prog_data_o,            // merged data
  output logic [7:0]              status_o,               // status byte
  output logic                    status_sel_o,           // reads give status
  output logic                    read_allowed_o,         // array read legal
  output logic                    erase_suspend_o,        // suspend pulse
  output logic                    prog_done_o,            // end/abort pulse
  output fwb_pkg::fwb_ctx_type    return_ctx_o            // context returned to
);
  // ==========================================================
  // types and state
  typedef enum logic [2:0] {
    S_READY, S_COUNT, S_LOAD, S_PROGRAM, S_SUSPEND
  } fwb_state_type;
  typedef struct packed {
    logic [28:0]          s1, s2, s3;    // pin synchroniser
    logic [28:0]          stb;           // agreed pin values
    logic                 clk_seen;      // clock latched address
    logic [23:0]          addr_lat;      // latched word address
    fwb_state_type        st;            // sequencer state
    fwb_pkg::fwb_ctx_type ctx;           // initiating context
    logic [7:0]           sector;        // load command sector
    logic                 page_set;      // first pair seen
    logic [18:0]          page;          // target page
    logic [5:0]           remaining;     // loads still expected
    logic [31:0]          mask;          // loaded word slots
    logic [31:0][15:0]    wbuf;          // write buffer
    logic [4:0]           idx;           // engine slot
    logic                 rd_pend;       // array read in flight
    logic                 in_valid;      // word to out buffer
    logic [23:0]          in_addr;       // its address
    logic [15:0]          in_data;       // its data
    logic [23:0]          rd_addr;       // array read address
    logic                 pfail;         // program fail flag
    logic                 lfail;         // sector lock flag
    logic                 status_sel;    // status read mode
    logic                 read_ok;       // read allowed
    logic [7:0]           status;        // status byte
    logic                 esusp;         // erase suspend pulse
    logic                 done;          // return pulse
    fwb_pkg::fwb_ctx_type ret_ctx;       // returned context
  } fwb_seq_type;
  fwb_seq_type s, next_s;
  // ==========================================================
  // helpers
  function automatic logic at_ofs(input logic [23:0] a, input logic [15:0] o);
    at_ofs = (a[fwb_pkg::SECTOR_LSB-1:0] == o);   // pattern in low bits
  endfunction : at_ofs
  function automatic logic [7:0] sec_of(input logic [23:0] a);
    sec_of = a[23:fwb_pkg::SECTOR_LSB];
  endfunction : sec_of
  // ==========================================================
  // output buffer between engine and array programmer
  fwb_word_if in_if ();
  fwb_word_if out_if ();
  logic buf_empty;
  assign in_if.valid  = s.in_valid;
  assign in_if.addr   = s.in_addr;
  assign in_if.data   = s.in_data;
  assign out_if.ready = prog_ready_i;
  fwb_pair_buf u_buf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_s    (in_if.snk),
    .out_s   (out_if.src),
    .empty_o (buf_empty)
  );
  // ==========================================================
  // decoded pin events
  logic        ce_n, we_n, oe_n, av_n, lclk;
  logic        av_rise, av_fall, lclk_rise, we_rise, wr_ev;
  logic [28:0] agreed;                            // pin values once stages agree
  logic [23:0] pin_addr;
  logic [15:0] cmd;
  logic [23:0] wa;
  logic        busy, sec_ok;
  always_comb begin
    // built here, not read back from next_s, so no loop through the struct
    agreed    = (s.s2 & s.s3) | ((s.s2 ^ s.s3) & s.stb);
    {ce_n, we_n, oe_n, av_n, lclk} = s.stb[28:24];
    pin_addr  = s.stb[23:0];
    av_rise   = ~s.stb[25] & agreed[25];
    av_fall   = s.stb[25] & ~agreed[25];
    lclk_rise = ~s.stb[24] & agreed[24];
    we_rise   = ~s.stb[27] & agreed[27];
    wr_ev     = we_rise & ~ce_n & oe_n;
    cmd       = pin_addr[15:0];                   // data at write rise
    wa        = s.addr_lat;
    sec_ok    = sec_of(wa) == s.sector;
    busy      = (s.st == S_PROGRAM);
  end
  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    // three-stage sampling, value taken once stages two and three agree
    next_s.s1  = {ce_n_i, we_n_i, oe_n_i, address_valid_n_i, link_clk_i,
                  addr_hi_i, adq_i};
    next_s.s2  = s.s1;
    next_s.s3  = s.s2;
    next_s.stb = agreed;
    next_s.esusp = 1'b0;
    next_s.done  = 1'b0;
    // address capture
    if (av_fall) next_s.clk_seen = 1'b0;
    if (!av_n && lclk_rise && read_mode_select_bit_i == fwb_pkg::READ_MODE_SYNC) begin
      next_s.addr_lat = pin_addr;
      next_s.clk_seen = 1'b1;
    end
    if (av_rise && (read_mode_select_bit_i != fwb_pkg::READ_MODE_SYNC
                     || !s.clk_seen))
      next_s.addr_lat = pin_addr;
    // command decode
    if (wr_ev) begin
      next_s.status_sel = 1'b0;
      if (erase_busy_i) begin
        if (cmd == fwb_pkg::CMD_ERASE_SUSPEND) next_s.esusp = 1'b1;
        if (cmd == fwb_pkg::CMD_STATUS_READ)   next_s.status_sel = 1'b1;
      end else begin
        if (cmd == fwb_pkg::CMD_STATUS_READ) next_s.status_sel = 1'b1;
        unique case (s.st)
          S_READY: begin
            if (cmd == fwb_pkg::CMD_BUF_LOAD && at_ofs(wa, fwb_pkg::OFS_CMD)) begin
              next_s.sector = sec_of(wa);
              next_s.ctx    = context_i;
              if (context_i == fwb_pkg::CTX_ERASE_SUSPEND
                  && sec_of(wa) == erase_sector_i) begin
                next_s.lfail   = 1'b1;
                next_s.done    = 1'b1;
                next_s.ret_ctx = context_i;
              end else begin
                next_s.st = S_COUNT;
              end
            end
            if (cmd == fwb_pkg::CMD_CLEAR_STATUS) begin
              next_s.pfail = 1'b0;
              next_s.lfail = 1'b0;
            end
          end
          S_COUNT: begin
            if (!sec_ok || !at_ofs(wa, fwb_pkg::OFS_COUNT) || !sector_unlocked_i
                || cmd > fwb_pkg::MAX_COUNT_M1) begin
              next_s.lfail   = sec_ok & ~sector_unlocked_i;
              next_s.st      = S_READY;
              next_s.done    = 1'b1;
              next_s.ret_ctx = s.ctx;
            end else begin
              next_s.remaining = 6'(cmd[4:0]) + 6'h01;
              next_s.mask      = '0;
              next_s.page_set  = 1'b0;
              next_s.st        = S_LOAD;
            end
          end
          S_LOAD: begin
            if (cmd == fwb_pkg::CMD_BUF_CONFIRM && sec_ok
                && at_ofs(wa, fwb_pkg::OFS_CMD)) begin
              if (s.remaining != 6'h00) begin
                next_s.pfail   = 1'b1;
                next_s.st      = S_READY;
                next_s.done    = 1'b1;
                next_s.ret_ctx = s.ctx;
              end else begin
                next_s.st      = S_PROGRAM;
                next_s.idx     = 5'h00;
                next_s.rd_pend = 1'b0;
              end
            end else if ((!s.page_set && !sec_ok) || s.remaining == 6'h00) begin
              next_s.pfail   = (s.remaining == 6'h00);
              next_s.st      = S_READY;
              next_s.done    = 1'b1;
              next_s.ret_ctx = s.ctx;
            end else if (s.page_set && wa[23:fwb_pkg::PAGE_LSB] != s.page) begin
              next_s.pfail   = 1'b1;
              next_s.st      = S_READY;
              next_s.done    = 1'b1;
              next_s.ret_ctx = s.ctx;
            end else begin
              next_s.page_set = 1'b1;
              next_s.page     = wa[23:fwb_pkg::PAGE_LSB];
              next_s.wbuf[wa[4:0]] = cmd;
              next_s.mask[wa[4:0]] = 1'b1;
              next_s.remaining     = s.remaining - 6'h01;
            end
          end
          S_PROGRAM: begin
            if (cmd == fwb_pkg::CMD_PGM_SUSPEND) next_s.st = S_SUSPEND;
          end
          S_SUSPEND: begin
            if (cmd == fwb_pkg::CMD_PGM_RESUME) next_s.st = S_PROGRAM;
          end
          default: next_s.st = S_READY;
        endcase
      end
    end
    // program engine: read old word, merge, push to buffer
    if (s.in_valid && in_if.ready) next_s.in_valid = 1'b0;
    if (s.st == S_PROGRAM && next_s.st == S_PROGRAM) begin
      if (s.rd_pend) begin
        next_s.in_valid = 1'b1;
        next_s.in_addr  = s.rd_addr;
        next_s.in_data  = arr_rd_data_i & s.wbuf[s.idx];
        next_s.mask[s.idx] = 1'b0;
        next_s.rd_pend  = 1'b0;
        next_s.idx      = s.idx + 5'h01;
      end else if (s.mask == '0) begin
        if (!s.in_valid && buf_empty) begin
          next_s.st      = S_READY;
          next_s.done    = 1'b1;
          next_s.ret_ctx = s.ctx;
        end
      end else if (!s.mask[s.idx]) begin
        next_s.idx = s.idx + 5'h01;
      end else if (!s.in_valid || in_if.ready) begin
        next_s.rd_addr = {s.page, s.idx};
        next_s.rd_pend = 1'b1;
      end
    end
    // read gating per bank and per suspended sector
    next_s.read_ok = 1'b1;
    if (busy && rd_sector_i[7:5] == s.sector[7:5]) next_s.read_ok = 1'b0;
    if (erase_busy_i && rd_sector_i[7:5] == erase_sector_i[7:5])
      next_s.read_ok = 1'b0;
    if (s.st == S_SUSPEND && rd_sector_i == s.sector) next_s.read_ok = 1'b0;
    if (context_i == fwb_pkg::CTX_ERASE_SUSPEND && rd_sector_i == erase_sector_i)
      next_s.read_ok = 1'b0;
    // status byte, detail bits only when ready
    next_s.status = fwb_pkg::STATUS_RESET;
    if (busy || erase_busy_i) begin
      next_s.status[fwb_pkg::ST_READY] = 1'b0;
      next_s.status[fwb_pkg::ST_BANK]  = busy ? (rd_sector_i[7:5] != s.sector[7:5])
                                       : (rd_sector_i[7:5] != erase_sector_i[7:5]);
    end else begin
      next_s.status[fwb_pkg::ST_PFAIL] = next_s.pfail;
      next_s.status[fwb_pkg::ST_PSUSP] = (next_s.st == S_SUSPEND);
      next_s.status[fwb_pkg::ST_LOCK]  = next_s.lfail;
    end
  end
  // ==========================================================
  // registers; reset ends any sequence at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s            <= '0;
      s.stb        <= 29'h1F000000;
      s.s1         <= 29'h1F000000;
      s.s2         <= 29'h1F000000;
      s.s3         <= 29'h1F000000;
      s.status     <= fwb_pkg::STATUS_RESET;
      s.read_ok    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  // ==========================================================
  // outputs
  assign arr_rd_addr_o        = s.rd_addr;
  assign sector_select_bits_o = s.sector;
  assign prog_valid_o         = out_if.valid;
  assign prog_addr_o          = out_if.addr;
  assign prog_data_o          = out_if.data;
  assign status_o             = s.status;
  assign status_sel_o         = s.status_sel;
  assign read_allowed_o       = s.read_ok;
  assign erase_suspend_o      = s.esusp;
  assign prog_done_o          = s.done;
  assign return_ctx_o         = s.ret_ctx;
endmodule : fwb_seq
`default_nettype wire

//--- tb/fwb_seq_monitor.sv
// port assertions of the buffered program sequencer
`timescale 1ns/1ps
`default_nettype none
module fwb_seq_monitor (
  input wire logic                 clk_i,                // core clock
  input wire logic                 rst_i,                // async reset, high
  input wire logic                 erase_busy_i,         // erase running
  input wire fwb_pkg::fwb_ctx_type context_i,            // current context
  input wire logic                 prog_ready_i,         // programmer ready
  input wire logic                 prog_valid_o,         // word to program
  input wire logic [23:0]          prog_addr_o,          // program address
  input wire logic [15:0]          prog_data_o,          // merged data
  input wire logic [7:0]           status_o,             // status byte
  input wire logic [7:0]           sector_select_bits_o, // target sector
  input wire logic                 erase_suspend_o,      // suspend pulse
  input wire logic                 prog_done_o,          // end/abort pulse
  input wire fwb_pkg::fwb_ctx_type return_ctx_o          // context returned to
);
  // ==========================================================
  // one clock domain, so clocking and reset are shared
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_busy_hides_flags: assert property (!status_o[7] |-> status_o[6:1] == 6'h00)
    else $error("status flags visible while busy");
  a_done_one_pulse: assert property (prog_done_o |=> !prog_done_o)
    else $error("done pulse longer than one cycle");
  // a stalled word must not move, or the programmer loses it
  a_word_held_stall: assert property (prog_valid_o && !prog_ready_i |=>
    prog_valid_o && $stable(prog_addr_o) && $stable(prog_data_o))
    else $error("word changed while stalled");
  a_word_in_sector: assert property (prog_valid_o |->
    prog_addr_o[23:16] == sector_select_bits_o)
    else $error("word outside target sector");
  a_words_ascend: assert property ((prog_valid_o && prog_ready_i) ##1 prog_valid_o |->
    prog_addr_o == $past(prog_addr_o) + 24'h000001)
    else $error("words not ascending by one");
  a_done_ctx_back: assert property (prog_done_o |-> return_ctx_o == context_i)
    else $error("wrong context after program");
  a_done_when_empty: assert property (prog_done_o |-> !prog_valid_o)
    else $error("done while words remain");
  a_suspend_in_erase: assert property (erase_suspend_o |-> erase_busy_i)
    else $error("erase suspend without erase");
endmodule : fwb_seq_monitor
bind fwb_seq fwb_seq_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .erase_busy_i(erase_busy_i),
  .context_i(context_i), .prog_ready_i(prog_ready_i), .prog_valid_o(prog_valid_o),
  .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o), .status_o(status_o),
  .sector_select_bits_o(sector_select_bits_o), .erase_suspend_o(erase_suspend_o),
  .prog_done_o(prog_done_o), .return_ctx_o(return_ctx_o));
`default_nettype wire

//--- tb/fwb_host_model.sv
// host controller model driving single word pin writes
`timescale 1ns/1ps
`default_nettype none
module fwb_host_model (
  input  wire logic        clk_i,             // bench clock, paces pins
  output logic             ce_n_o,            // chip select
  output logic             we_n_o,            // write strobe
  output logic             oe_n_o,            // output enable
  output logic             address_valid_n_o, // address strobe
  output logic             link_clk_o,        // bus clock
  output logic [15:0]      adq_o,             // addr/data
  output logic [7:0]       addr_hi_o          // upper address
);
  // ==========================================================
  // idle pins at time zero, bus clock parked low
  initial begin
    {ce_n_o, we_n_o, oe_n_o, address_valid_n_o, link_clk_o} = 5'h1E;
    adq_o = 16'hA5A5;
    addr_hi_o = 8'h5A;
  end
  // one async word write; s adds one bus clock period in the address phase
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic s);
    @(negedge clk_i);
    {ce_n_o, oe_n_o, address_valid_n_o} = 3'h2;
    {addr_hi_o, adq_o} = a;
    repeat (3) @(negedge clk_i);
    link_clk_o = s; // rises only inside a frame
    repeat (6) @(negedge clk_i);
    link_clk_o = 1'b0; // low again before the address strobe rises
    repeat (3) @(negedge clk_i);
    address_valid_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    adq_o = d;
    we_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    we_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    ce_n_o = 1'b1;
    // released bus shows the inverse, not the last value
    {addr_hi_o, adq_o} = ~{a[23:16], d};
    repeat (6) @(negedge clk_i);
  endtask : wr
endmodule : fwb_host_model
`default_nettype wire

//--- tb/tb.sv
// scenario testbench of the buffered program sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [23:0] SC = 24'h050555;  // load/confirm place
  localparam logic [23:0] SN = 24'h0502AA;  // count place
  logic        clk_i, rst_i, ce_n, we_n, oe_n, av_n, lclk, rmode, ebusy, unl, rdy, sy;
  logic        pvalid, ssel, rd_ok, esusp, done;     // design flags
  logic [15:0] adq, arr, pdata;                       // data words
  logic [7:0]  ahi, esec, rsec, sel, st;              // sectors, status
  logic [23:0] raddr, paddr;                          // addresses
  fwb_pkg::fwb_ctx_type ctx, rctx;                    // contexts
  int          errors, checks, dones, esusps;         // tallies
  // ==========================================================
  // design, host, array model
  fwb_host_model host (.clk_i(clk_i), .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n),
    .address_valid_n_o(av_n), .link_clk_o(lclk), .adq_o(adq), .addr_hi_o(ahi));
  fwb_seq dut (.clk_i(clk_i), .rst_i(rst_i), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .address_valid_n_i(av_n), .link_clk_i(lclk), .adq_i(adq), .addr_hi_i(ahi),
    .read_mode_select_bit_i(rmode), .context_i(ctx), .erase_busy_i(ebusy),
    .erase_sector_i(esec), .sector_unlocked_i(unl), .rd_sector_i(rsec), .arr_rd_data_i(arr),
    .prog_ready_i(rdy), .arr_rd_addr_o(raddr), .sector_select_bits_o(sel),
    .prog_valid_o(pvalid), .prog_addr_o(paddr), .prog_data_o(pdata), .status_o(st),
    .status_sel_o(ssel), .read_allowed_o(rd_ok), .erase_suspend_o(esusp),
    .prog_done_o(done), .return_ctx_o(rctx));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // stored word pattern follows the read address within the cycle
  assign arr = {8'hF0, raddr[7:0]};
  // pulse tallies
  always @(posedge clk_i) begin
    if (done === 1'b1) dones++;
    if (esusp === 1'b1) esusps++;
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task w(input logic [23:0] a, input logic [15:0] d);
    host.wr(a, d, sy);
  endtask : w
  // bounded wait for a word or for the done tally to reach n
  task await_evt(input bit fd, input int n);
    int i;
    for (i = 0; i < 500; i++) begin
      if (fd ? dones >= n : pvalid === 1'b1) break;
      @(negedge clk_i);
    end
    if (i == 500) begin
      errors++;
      $display("MISMATCH %0t wait ran out", $time);
      conclude();
    end
  endtask : await_evt
  // ==========================================================
  // two word program, stalled sink, suspend and resume in flight
  task t_prog(input logic s);
    int n0;
    n0 = dones;
    sy = s;
    ctx = fwb_pkg::CTX_ERASE_SUSPEND; // other sector suspended
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0001);
    w(24'h050040, 16'h1234);
    w(24'h050041, 16'h00FF);
    w(SC, fwb_pkg::CMD_BUF_CONFIRM);
    chk(st[7], 1'b0);
    chk(rd_ok, 1'b1);
    rsec = 8'h06; // read aimed at the busy bank
    repeat (2) @(negedge clk_i);
    chk(rd_ok, 1'b0);
    rsec = 8'h45;
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(24'h050000, fwb_pkg::CMD_PGM_SUSPEND);
    chk(st[2], 1'b1);
    w(24'h050000, fwb_pkg::CMD_PGM_RESUME);
    for (int k = 0; k < 2; k++) begin
      await_evt(0, 0);
      chk(paddr, 24'h050040 + k);
      chk(pdata, k ? 16'h0041 : 16'h1000);
      rdy = 1'b1;
      @(negedge clk_i);
      rdy = 1'b0;
      @(negedge clk_i);
    end
    await_evt(1, n0 + 1);
    chk(rctx, fwb_pkg::CTX_ERASE_SUSPEND);
    chk(st[4], 1'b0);
    $display("t_prog finished");
  endtask : t_prog
  // aborts and failures, each cleared afterwards
  task t_faults;
    int n0;
    n0 = dones;
    sy = 1'b0;
    ctx = fwb_pkg::CTX_IDLE;
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0020);
    chk(dones, n0 + 1);
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(24'h0602AA, 16'h0000);
    chk(dones, n0 + 2);
    unl = 1'b0;
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0000);
    unl = 1'b1;
    chk(st[1], 1'b1);
    w(SC, fwb_pkg::CMD_CLEAR_STATUS);
    chk(st, 8'h80);
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0001);
    w(24'h050040, 16'h0000);
    w(24'h050060, 16'h0000);
    chk(st[4], 1'b1);
    w(SC, fwb_pkg::CMD_CLEAR_STATUS);
    chk(st[4], 1'b0);
    rdy = 1'b1;
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0001);
    w(24'h050040, 16'h0000);
    w(SC, fwb_pkg::CMD_BUF_CONFIRM);
    chk(st[4], 1'b1);
    rdy = 1'b0;
    w(SC, fwb_pkg::CMD_CLEAR_STATUS);
    $display("t_faults finished");
  endtask : t_faults
  // commands during erase, then a load into the suspended sector
  task t_erase;
    int n0;
    n0 = esusps;
    {ebusy, esec} = 9'h105;
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    chk(rd_ok, 1'b1);
    w(24'h050000, fwb_pkg::CMD_ERASE_SUSPEND);
    chk(esusps, n0 + 1);
    w(SC, fwb_pkg::CMD_STATUS_READ);
    chk(ssel, 1'b1);
    ebusy = 1'b0;
    ctx = fwb_pkg::CTX_ERASE_SUSPEND; // erase now suspended
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0000);
    w(24'h050040, 16'h0000);
    chk(st[1], 1'b1);
    w(SC, fwb_pkg::CMD_CLEAR_STATUS);
    esec = 8'h07;
    ctx = fwb_pkg::CTX_IDLE;
    $display("t_erase finished");
  endtask : t_erase
  // reset in mid-sequence drops it; a late confirm programs nothing
  task t_reset;
    w(SC, fwb_pkg::CMD_BUF_LOAD);
    w(SN, 16'h0001);
    w(24'h050040, 16'h0000);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({st, rd_ok, pvalid}, 10'h202);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    w(24'h050041, 16'h0000);
    w(SC, fwb_pkg::CMD_BUF_CONFIRM);
    chk(pvalid, 1'b0);
    $display("t_reset finished");
  endtask : t_reset
  // ==========================================================
  // main sequence
  initial begin
    {rst_i, rmode, ebusy, unl, rdy, sy} = 6'h34;
    {esec, rsec} = 16'h0745;
    ctx = fwb_pkg::CTX_IDLE;
    repeat (3) @(negedge clk_i);
    chk(st, 8'h80);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_prog(1'b0);
    rmode = fwb_pkg::READ_MODE_SYNC;
    t_prog(1'b1);
    rmode = 1'b1;
    t_faults();
    t_erase();
    t_reset();
    conclude();
  end
endmodule : tb
`default_nettype wire
